// file: verilog/tcc_regs.vh
// Register offsets, field positions, reset values and timing counts of the capture timer
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// ============================================================
// Register byte addresses
`define TCC_ADDR_TIMER_CONTROL 32'h5000_4000
`define TCC_ADDR_CAPTURE_CONTROL 32'h5000_4004
`define TCC_ADDR_COUNTER_STATUS 32'h5000_4008
`define TCC_ADDR_INPUT1_VALUE 32'h5000_400c
`define TCC_ADDR_INPUT2_VALUE 32'h5000_4010
`define TCC_ADDR_EVENT_CLEAR 32'h5000_4014

// ============================================================
// Reset values
`define TCC_RST_TIMER_CONTROL 17'h0_0000
`define TCC_RST_CAPTURE_CONTROL 28'h000_0000

// ============================================================
// timer_control fields
`define TCC_TC_CLOCK_GATE 16
`define TCC_TC_FAST_CLOCK 15
`define TCC_TC_WRAP_MAX 14
`define TCC_TC_IRQ_UNMASK 13
`define TCC_TC_DECREMENT 12
`define TCC_TC_RUN 11
`define TCC_TC_RELOAD_HI 10
`define TCC_TC_RELOAD_LO 0

// ============================================================
// capture_control fields of input 1; input 2 sits one stride above
`define TCC_CC_STRIDE 14
`define TCC_CC_PIN_LO 0
`define TCC_CC_FALLING 4
`define TCC_CC_MEASURE 5
`define TCC_CC_IRQ_UNMASK 6
`define TCC_CC_WINDOW_LO 7
`define TCC_CC_STAMP_SRC 13

// ============================================================
// counter_status fields
`define TCC_ST_CH1_MISSED 14
`define TCC_ST_CH1_PENDING 12
`define TCC_ST_WRAP_PENDING 11

// ============================================================
// event_clear fields
`define TCC_CLR_WRAP 0
`define TCC_CLR_CH1 1

// ============================================================
// Timing
`define TCC_RUN_SYNC_CYCLES 3
`define TCC_LP_DIVIDE 3815

`endif

// file: verilog/tcc_input_channel.v
// One input channel of the capture timer: edge detect, capture, period measure, flags
`timescale 1ns/1ps

module tcc_input_channel #(
  parameter NPINS = 12,
  parameter CW = 11,
  parameter PW = 6
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_tick,
  input wire [NPINS-1:0] i_pins,
  input wire [3:0] i_pin_sel,
  input wire i_falling,
  input wire i_measure,
  input wire [PW-1:0] i_window,
  input wire i_stamp_src,
  input wire [CW-1:0] i_count,
  input wire [2*CW-1:0] i_rtc,
  input wire i_clear,
  output reg o_pending,
  output reg o_missed,
  output reg [2*CW-1:0] o_result
);

  // ============================================================
  // Pin selection and edge detection
  wire pin_valid;
  wire [3:0] pin_idx;
  wire level;
  reg prev_level;
  wire edge_seen;
  assign pin_valid = (i_pin_sel != 4'h0) && ({28'h0, i_pin_sel} <= NPINS);
  assign pin_idx = i_pin_sel - 4'h1;
  // A disabled channel sees a steady low, so it raises no events except one falling edge if its pin was high
  assign level = pin_valid ? i_pins[pin_idx] : 1'b0;
  assign edge_seen = i_falling ? (prev_level & ~level) : (~prev_level & level);

  // ============================================================
  // Period measurement state
  reg active;
  reg [PW-1:0] periods;
  reg [CW-1:0] cycles;
  wire done;
  wire capture_ev;
  wire ev;
  reg [2*CW-1:0] next_value;
  assign done = i_measure & edge_seen & active & (periods == i_window);
  assign capture_ev = ~i_measure & edge_seen;
  assign ev = done | capture_ev;

  // Value stored on an event
  always @* begin
    if (i_measure) begin
      // The tick at the closing edge still belongs to the window, so it is counted here
      next_value = {{CW{1'b0}}, cycles + {{(CW-1){1'b0}}, i_tick} - {{(CW-1){1'b0}}, 1'b1}};
    end else if (i_stamp_src) begin
      next_value = i_rtc;
    end else begin
      next_value = {{CW{1'b0}}, i_count};
    end
  end

  // Window runs from one edge to the window-plus-one-th edge after it
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      prev_level <= 1'b0;
      active <= 1'b0;
      periods <= {PW{1'b0}};
      cycles <= {CW{1'b0}};
    end else begin
      prev_level <= level;
      if (!i_measure) begin
        active <= 1'b0;
      end else if (edge_seen && (!active || done)) begin
        active <= 1'b1;
        periods <= {PW{1'b0}};
        cycles <= {CW{1'b0}};
      end else begin
        if (edge_seen) begin
          periods <= periods + {{(PW-1){1'b0}}, 1'b1};
        end
        if (active && i_tick) begin
          cycles <= cycles + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Flags: a new event beats a clear in the same cycle; first stamp is kept
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_pending <= 1'b0;
      o_missed <= 1'b0;
      o_result <= {2*CW{1'b0}};
    end else begin
      o_pending <= ev | (o_pending & ~i_clear);
      o_missed <= (ev & o_pending & ~i_clear) | (o_missed & ~i_clear);
      if (ev && (!o_pending || i_clear)) begin
        o_result <= next_value;
      end
    end
  end

endmodule // tcc_input_channel

// file: verilog/tcc_timer.v
// Capture timer top: register port, 11-bit counter, two input channels
`timescale 1ns/1ps
`include "tcc_regs.vh"

module tcc_timer #(
  parameter NPINS = 12,
  parameter CW = 11,
  parameter PW = 6,
  parameter LP_DIV = `TCC_LP_DIVIDE
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [31:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire [NPINS-1:0] i_port_pins,
  input wire [2*CW-1:0] i_rtc_stamp,
  output wire o_timer_irq,
  output wire o_capture_irq
);

  // ============================================================
  // Software registers
  reg [16:0] timer_control;
  reg [27:0] capture_control;

  wire counter_clock_gate;
  wire fast_clock_select;
  wire wrap_at_maximum;
  wire timer_irq_unmask;
  wire decrement_select;
  wire counter_run;
  wire [CW-1:0] reload_value;

  assign counter_clock_gate = timer_control[`TCC_TC_CLOCK_GATE];
  assign fast_clock_select = timer_control[`TCC_TC_FAST_CLOCK];
  assign wrap_at_maximum = timer_control[`TCC_TC_WRAP_MAX];
  assign timer_irq_unmask = timer_control[`TCC_TC_IRQ_UNMASK];
  assign decrement_select = timer_control[`TCC_TC_DECREMENT];
  assign counter_run = timer_control[`TCC_TC_RUN];
  assign reload_value = timer_control[`TCC_TC_RELOAD_HI:`TCC_TC_RELOAD_LO];

  // Decoded accesses
  wire wr_timer_control;
  wire wr_capture_control;
  wire wr_event_clear;
  assign wr_timer_control = i_wr && (i_addr == `TCC_ADDR_TIMER_CONTROL);
  assign wr_capture_control = i_wr && (i_addr == `TCC_ADDR_CAPTURE_CONTROL);
  assign wr_event_clear = i_wr && (i_addr == `TCC_ADDR_EVENT_CLEAR);

  // Clear strobes last a single cycle; a written zero leaves flags alone
  wire wrap_flag_clear;
  wire ch1_flag_clear;
  wire ch2_flag_clear;
  assign wrap_flag_clear = wr_event_clear & i_wdata[`TCC_CLR_WRAP];
  assign ch1_flag_clear = wr_event_clear & i_wdata[`TCC_CLR_CH1];
  assign ch2_flag_clear = wr_event_clear & i_wdata[`TCC_CLR_CH1+1];

  // Control register writes
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      timer_control <= `TCC_RST_TIMER_CONTROL;
      capture_control <= `TCC_RST_CAPTURE_CONTROL;
    end else begin
      if (wr_timer_control) begin
        timer_control <= i_wdata[16:0];
      end
      if (wr_capture_control) begin
        capture_control <= i_wdata[27:0];
      end
    end
  end

  // ============================================================
  // Tick generation
  // The low-power rate is an enable pulse from a divider, not a clock,
  // so the whole block stays in one domain.
  reg [15:0] lp_div_cnt;
  wire lp_tick;
  wire tick;
  assign lp_tick = (lp_div_cnt == LP_DIV[15:0] - 16'h0001);

  // Divider only runs while the gate is open, saving toggles when idle
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      lp_div_cnt <= 16'h0000;
    end else if (!counter_clock_gate || lp_tick) begin
      lp_div_cnt <= 16'h0000;
    end else begin
      lp_div_cnt <= lp_div_cnt + 16'h0001;
    end
  end

  assign tick = counter_clock_gate & (fast_clock_select | lp_tick);

  // ============================================================
  // Run synchroniser
  // Start and stop pass three flops, matching the documented start latency.
  reg [`TCC_RUN_SYNC_CYCLES-1:0] run_sync;
  wire run_q;
  assign run_q = run_sync[`TCC_RUN_SYNC_CYCLES-1];

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      run_sync <= {`TCC_RUN_SYNC_CYCLES{1'b0}};
    end else begin
      run_sync <= {run_sync[`TCC_RUN_SYNC_CYCLES-2:0], counter_run};
    end
  end

  // ============================================================
  // Counter
  reg [CW-1:0] live_count;
  reg [CW-1:0] next_count;
  reg wrap_ev;
  wire [CW-1:0] up_top;
  assign up_top = wrap_at_maximum ? {CW{1'b1}} : reload_value;

  // Next count and wrap event
  always @* begin
    next_count = live_count;
    wrap_ev = 1'b0;
    if (!run_q) begin
      // Idle: preset so the first run starts from a known end
      next_count = decrement_select ? reload_value : {CW{1'b0}};
    end else if (tick) begin
      if (decrement_select) begin
        if (live_count == {CW{1'b0}}) begin
          next_count = reload_value;
          wrap_ev = 1'b1;
        end else begin
          next_count = live_count - {{(CW-1){1'b0}}, 1'b1};
        end
      end else begin
        // Compare with >= so a reload lowered below the count still wraps
        if (live_count >= up_top) begin
          next_count = {CW{1'b0}};
          wrap_ev = 1'b1;
        end else begin
          next_count = live_count + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Counter flop and wrap flag; a new wrap beats a clear in the same cycle
  reg wrap_pending;
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      live_count <= {CW{1'b0}};
      wrap_pending <= 1'b0;
    end else begin
      live_count <= next_count;
      wrap_pending <= wrap_ev | (wrap_pending & ~wrap_flag_clear);
    end
  end

  // ============================================================
  // Input channels
  wire [1:0] ch_pending;
  wire [1:0] ch_missed;
  wire [1:0] ch_irq_unmask;
  wire [1:0] ch_clear;
  wire [4*CW-1:0] ch_result;
  assign ch_clear = {ch2_flag_clear, ch1_flag_clear};

  // Channel c finds its fields one stride above channel c-1
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      localparam B = c * `TCC_CC_STRIDE;
      assign ch_irq_unmask[c] = capture_control[B+`TCC_CC_IRQ_UNMASK];
      tcc_input_channel #(
        .NPINS(NPINS),
        .CW(CW),
        .PW(PW)
      ) u_ch (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_tick(tick),
        .i_pins(i_port_pins),
        .i_pin_sel(capture_control[B+`TCC_CC_PIN_LO+3:B+`TCC_CC_PIN_LO]),
        .i_falling(capture_control[B+`TCC_CC_FALLING]),
        .i_measure(capture_control[B+`TCC_CC_MEASURE]),
        .i_window(capture_control[B+`TCC_CC_WINDOW_LO+PW-1:B+`TCC_CC_WINDOW_LO]),
        .i_stamp_src(capture_control[B+`TCC_CC_STAMP_SRC]),
        .i_count(live_count),
        .i_rtc(i_rtc_stamp),
        .i_clear(ch_clear[c]),
        .o_pending(ch_pending[c]),
        .o_missed(ch_missed[c]),
        .o_result(ch_result[c*2*CW+2*CW-1:c*2*CW])
      );
    end
  endgenerate

  // ============================================================
  // Interrupt outputs
  // Masking only gates the outputs; the flags still set and read back.
  assign o_timer_irq = wrap_pending & timer_irq_unmask;
  assign o_capture_irq = |(ch_pending & ch_irq_unmask);

  // ============================================================
  // Read path
  reg [31:0] next_rdata;

  // Unmapped addresses and the clear register read as zero
  always @* begin
    next_rdata = 32'h0000_0000;
    case (i_addr)
      `TCC_ADDR_TIMER_CONTROL: begin
        next_rdata = {15'h0000, timer_control};
      end
      `TCC_ADDR_CAPTURE_CONTROL: begin
        next_rdata = {4'h0, capture_control};
      end
      `TCC_ADDR_COUNTER_STATUS: begin
        next_rdata[`TCC_ST_CH1_MISSED+1:`TCC_ST_CH1_MISSED] = ch_missed;
        next_rdata[`TCC_ST_CH1_PENDING+1:`TCC_ST_CH1_PENDING] = ch_pending;
        next_rdata[`TCC_ST_WRAP_PENDING] = wrap_pending;
        next_rdata[CW-1:0] = live_count;
      end
      `TCC_ADDR_INPUT1_VALUE: begin
        next_rdata = {10'h000, ch_result[2*CW-1:0]};
      end
      `TCC_ADDR_INPUT2_VALUE: begin
        next_rdata = {10'h000, ch_result[4*CW-1:2*CW]};
      end
      `TCC_ADDR_EVENT_CLEAR: begin
        next_rdata = 32'h0000_0000;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule // tcc_timer

// file: tb/tcc_timer_props.sv
// Concurrent checks on the capture timer register port and interrupt outputs
`timescale 1ns/1ps
`include "tcc_regs.vh"

module tcc_timer_props (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [31:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire o_timer_irq,
  input wire o_capture_irq
);
  // ============================================================
  // Shadows of the control registers, so outputs can be tied to what software wrote
  reg [16:0] ctl;
  reg [27:0] cap;
  wire rd_ctl = i_rd && i_addr == `TCC_ADDR_TIMER_CONTROL;
  wire rd_cap = i_rd && i_addr == `TCC_ADDR_CAPTURE_CONTROL;
  wire rd_stat = i_rd && i_addr == `TCC_ADDR_COUNTER_STATUS;
  wire rd_clr = i_rd && i_addr == `TCC_ADDR_EVENT_CLEAR;
  wire rd_gap = i_rd && (i_addr[31:5] != 27'h280_0200 || i_addr[4:0] > 5'h14 || i_addr[1:0] != 2'h0);

  // Shadow update on register writes
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ctl <= 17'h0_0000;
      cap <= 28'h000_0000;
    end else begin
      if (i_wr && i_addr == `TCC_ADDR_TIMER_CONTROL) ctl <= i_wdata[16:0];
      if (i_wr && i_addr == `TCC_ADDR_CAPTURE_CONTROL) cap <= i_wdata[27:0];
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  // ============================================================
  // Properties
  // Six cycles stopped and counting up is longer than the three-stage run sync
  sequence s_stopped_up;
    (!ctl[11] && !ctl[12]) [*6];
  endsequence
  sequence s_status_read;
    rd_stat;
  endsequence

  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_CTRL_BACK: assert property (rd_ctl |=> o_rdata == {15'h0, ctl})
    else $error("timer control read back wrong");
  AST_CAP_BACK: assert property (rd_cap |=> o_rdata == {4'h0, cap})
    else $error("capture control read back wrong");
  AST_CLEAR_ZERO: assert property (rd_clr |=> o_rdata == 32'h0)
    else $error("clear register did not read zero");
  AST_UNMAPPED: assert property (rd_gap |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_STOPPED_COUNT: assert property (s_stopped_up ##0 s_status_read |=> o_rdata[10:0] == 11'h0)
    else $error("stopped up counter not preset to zero");
  AST_TIRQ_MASK: assert property (o_timer_irq |-> ctl[13])
    else $error("timer interrupt while masked");
  AST_CIRQ_MASK: assert property (o_capture_irq |-> cap[6] || cap[20])
    else $error("capture interrupt while masked");
  AST_TIRQ_HOLD: assert property (o_timer_irq && !i_wr |=> o_timer_irq)
    else $error("timer interrupt dropped without a write");
  AST_CIRQ_HOLD: assert property (o_capture_irq && !i_wr |=> o_capture_irq)
    else $error("capture interrupt dropped without a write");
endmodule // tcc_timer_props

bind tcc_timer tcc_timer_props u_props (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_timer_irq(o_timer_irq), .o_capture_irq(o_capture_irq));

// file: tb/tcc_pin_source.sv
// Port pin model: static levels or a square wave on pin 0, synchronous to the clock
`timescale 1ns/1ps

module tcc_pin_source (
  input wire i_core_clk,
  input wire [11:0] i_level,
  input wire i_toggle_on,
  input wire [3:0] i_half,
  output reg [11:0] o_pins
);
  reg [3:0] cnt;

  // ============================================================
  // Pins move only after a clock edge, as a synchronised port would deliver them
  initial o_pins = 12'h000;
  initial cnt = 4'h0;
  always @(posedge i_core_clk) begin
    if (!i_toggle_on) begin
      o_pins <= i_level;
      cnt <= 4'h0;
    end else if (cnt == i_half - 4'h1) begin
      cnt <= 4'h0;
      o_pins[0] <= ~o_pins[0]; // Exact period, so the measured count is known
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // tcc_pin_source

// file: tb/tcc_timer_bench.sv
// Self-checking bench for the capture timer through its register port
`timescale 1ns/1ps
`include "tcc_regs.vh"

module tcc_timer_bench;
  reg i_core_clk = 1'b0;
  reg i_nrst = 1'b0;
  reg [31:0] i_addr = 32'h0;
  reg [31:0] i_wdata = 32'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg [21:0] i_rtc_stamp = 22'h0;
  reg [11:0] level = 12'h000;
  reg toggle_on = 1'b0;
  wire [11:0] pins;
  wire [31:0] o_rdata;
  wire o_timer_irq;
  wire o_capture_irq;
  integer errors = 0;
  integer tests_run = 0;
  integer cycles = 0;
  integer i;
  reg [31:0] a;
  reg [31:0] b;
  reg [3:0] off [0:3];

  always #4 i_core_clk = ~i_core_clk;

  tcc_timer #(.LP_DIV(4)) i_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_pins(pins),
    .i_rtc_stamp(i_rtc_stamp), .o_timer_irq(o_timer_irq), .o_capture_irq(o_capture_irq));
  tcc_pin_source u_pins (.i_core_clk(i_core_clk), .i_level(level), .i_toggle_on(toggle_on),
    .i_half(4'h5), .o_pins(pins));

  // ============================================================
  // Bus tasks and comparison
  task wr(input [31:0] ad, input [31:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input [31:0] ad, output [31:0] d);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata; // Answer stands only in this cycle
  endtask
  task chk(input string name, input [31:0] exp, input [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, far above the length of the sequence
  always @(posedge i_core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      results;
    end
  end

  // ============================================================
  // Main sequence
  initial begin
    off[0] = 4'h0;
    off[1] = 4'hd;
    off[2] = 4'he;
    off[3] = 4'hf;
    repeat (6) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    // Reset values, read-only places and an unmapped address
    wr(`TCC_ADDR_COUNTER_STATUS, 32'hffff_ffff);
    wr(32'h5000_4018, 32'hffff_ffff);
    for (i = 0; i < 7; i = i + 1) begin
      rd(32'h5000_4000 + 4 * i, a);
      chk("reset value", 32'h0, a);
    end
    // Stopped down counter is preset to the reload value
    wr(`TCC_ADDR_TIMER_CONTROL, 32'h0000_1005);
    repeat (6) @(posedge i_core_clk);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    chk("down preset", 32'h5, a[10:0]);
    // Fast clock counts each cycle, slow one each fourth cycle
    wr(`TCC_ADDR_TIMER_CONTROL, 32'h0001_cfff);
    rd(`TCC_ADDR_TIMER_CONTROL, a);
    chk("control back", 32'h0001_cfff, a);
    repeat (10) @(posedge i_core_clk);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    rd(`TCC_ADDR_COUNTER_STATUS, b);
    chk("fast rate", 32'h2, b[10:0] - a[10:0]);
    wr(`TCC_ADDR_TIMER_CONTROL, 32'h0001_4fff);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    repeat (14) @(posedge i_core_clk);
    rd(`TCC_ADDR_COUNTER_STATUS, b);
    chk("slow rate", 32'h4, b[10:0] - a[10:0]);
    wr(`TCC_ADDR_TIMER_CONTROL, 32'h0000_cfff);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    repeat (5) @(posedge i_core_clk);
    rd(`TCC_ADDR_COUNTER_STATUS, b);
    chk("gated frozen", a, b);
    // Wrap at reload value, flag and its mask, then clearing
    wr(`TCC_ADDR_TIMER_CONTROL, 32'h0001_8802);
    repeat (10) @(posedge i_core_clk);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    chk("wrap flag", 32'h1, a[11]);
    chk("below reload", 32'h1, a[10:0] <= 11'h2);
    chk("timer irq masked", 32'h0, o_timer_irq);
    wr(`TCC_ADDR_TIMER_CONTROL, 32'h0000_a802);
    repeat (4) @(posedge i_core_clk);
    chk("timer irq on", 32'h1, o_timer_irq);
    wr(`TCC_ADDR_EVENT_CLEAR, 32'h0);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    chk("zero clear kept", 32'h1, a[11]);
    wr(`TCC_ADDR_EVENT_CLEAR, 32'h1);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    chk("wrap cleared", 32'h0, {a[11], o_timer_irq});
    wr(`TCC_ADDR_TIMER_CONTROL, 32'h0);
    // Channel one: clock stamp capture, then a missed event keeps the first stamp
    i_rtc_stamp <= 22'h2a_5c3;
    wr(`TCC_ADDR_CAPTURE_CONTROL, 32'h0000_2041);
    rd(`TCC_ADDR_CAPTURE_CONTROL, a);
    chk("capture back", 32'h0000_2041, a);
    level <= 12'h001;
    repeat (3) @(posedge i_core_clk);
    rd(`TCC_ADDR_INPUT1_VALUE, a);
    chk("ch1 stamp", 32'h002a_5c3, a);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    chk("ch1 pending", 32'h02, a[15:11]);
    chk("capture irq", 32'h1, o_capture_irq);
    i_rtc_stamp <= 22'h15_a3c;
    level <= 12'h000;
    repeat (3) @(posedge i_core_clk);
    level <= 12'h001;
    repeat (3) @(posedge i_core_clk);
    rd(`TCC_ADDR_INPUT1_VALUE, a);
    chk("first stamp kept", 32'h002a_5c3, a);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    chk("ch1 missed", 32'h0a, a[15:11]);
    wr(`TCC_ADDR_EVENT_CLEAR, 32'h2);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    chk("ch1 cleared", 32'h0, {a[15:11], o_capture_irq});
    // Channel two on falling edges; edge bit written together with the pin select
    level <= 12'h000;
    wr(`TCC_ADDR_CAPTURE_CONTROL, 32'h0);
    i_rtc_stamp <= 22'h1b_0e4;
    wr(`TCC_ADDR_CAPTURE_CONTROL, 32'h0814_8000);
    level <= 12'h002;
    repeat (3) @(posedge i_core_clk);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    chk("no rising event", 32'h0, a[15:11]);
    level <= 12'h000;
    repeat (3) @(posedge i_core_clk);
    rd(`TCC_ADDR_INPUT2_VALUE, a);
    chk("ch2 stamp", 32'h001b_0e4, a);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    chk("ch2 pending", 32'h04, a[15:11]);
    wr(`TCC_ADDR_EVENT_CLEAR, 32'h4);
    rd(`TCC_ADDR_COUNTER_STATUS, a);
    chk("ch2 cleared", 32'h0, a[15:11]);
    // Disabling select codes ignore every pin
    for (i = 0; i < 4; i = i + 1) begin
      wr(`TCC_ADDR_CAPTURE_CONTROL, 32'h0010_0040 | off[i] | (off[i] << 14));
      level <= 12'hfff;
      repeat (3) @(posedge i_core_clk);
      level <= 12'h000;
      repeat (3) @(posedge i_core_clk);
      rd(`TCC_ADDR_COUNTER_STATUS, a);
      chk("disabled input", 32'h0, a[15:11]);
    end
    // Measure mode: window field 1 spans two pin periods of 10 cycles
    wr(`TCC_ADDR_CAPTURE_CONTROL, 32'h0);
    wr(`TCC_ADDR_TIMER_CONTROL, 32'h0001_cfff);
    wr(`TCC_ADDR_CAPTURE_CONTROL, 32'h0000_00a1);
    toggle_on <= 1'b1;
    a = 32'h0;
    for (i = 0; i < 30 && a[12] !== 1'b1; i = i + 1) begin
      rd(`TCC_ADDR_COUNTER_STATUS, a);
    end
    rd(`TCC_ADDR_INPUT1_VALUE, b);
    chk("measured cycles", 32'h13, b[10:0]);
    chk("measure irq masked", 32'h0, o_capture_irq);
    toggle_on <= 1'b0;
    results;
  end
endmodule // tcc_timer_bench
